// [inc/bank_close_pkg.sv]
// Functional notes
// - One write mask input per byte lane; masked byte skipped for that beat.
// - Masks use the data bit strobe timing and are inputs only.
// - Close command: select low, command bits 0..3 high, high, low, high.
// - Rising bit 4 is the all-bank flag, bits 7..9 the bank number.
// - Write data is committed in groups of four latched beats.
// - Auto-close flag low leaves the bank open after the burst.
// - Auto-close flag is falling-edge command bit 0 of read or write.
// - Read auto-close starts at the later of half burst or read limit.
// - Write auto-close starts recovery cycles after the write burst ends.
// - Effective burst length is twice the cycles from command to terminate.
package bank_close_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int BL_LSB = 0;
  localparam int WL_LSB = 8;
  localparam int RTP_LSB = 16;
  localparam int WR_LSB = 24;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int LINK_PERIOD_NS = 80;
  localparam int RTP_TIME_NS = 8;
  localparam int WR_TIME_NS = 15;
  localparam int RTP_CYCLES = (RTP_TIME_NS + LINK_PERIOD_NS - 1) /
                              LINK_PERIOD_NS;
  localparam int WR_CYCLES = (WR_TIME_NS + LINK_PERIOD_NS - 1) /
                             LINK_PERIOD_NS;
  localparam logic [4:0] BL_RESET = 5'h08;
  localparam logic [3:0] WL_RESET = 4'h2;
  localparam logic [31:0] CTRL_RESET = {4'h0, 4'(WR_CYCLES), 4'h0,
                                        4'(RTP_CYCLES), 4'h0, WL_RESET,
                                        3'h0, BL_RESET};
  localparam int GROUP_BEATS = 4;

  // ****************************************************************
  // Commands
  // ****************************************************************
  typedef enum logic [4:0] {
    CMD_NONE = 5'h01,
    CMD_READ = 5'h02,
    CMD_WRITE = 5'h04,
    CMD_TERM = 5'h08,
    CMD_CLOSE = 5'h10
  } cmd_t;

  // Decodes the rising-edge command bits.
  function automatic cmd_t decodeCmd(input logic [9:0] ca);
    if (ca[2:0] == 3'h5) begin
      return CMD_READ;
    end else if (ca[2:0] == 3'h1) begin
      return CMD_WRITE;
    end else if (ca[3:0] == 4'h3) begin
      return CMD_TERM;
    end else if (ca[3:0] == 4'hb) begin
      return CMD_CLOSE;
    end else begin
      return CMD_NONE;
    end
  endfunction : decodeCmd

  // Link cycles from command to the start of an automatic close.
  function automatic logic [6:0] autoDelay(input logic isWrite,
      input logic [4:0] half, input logic [3:0] wl, input logic [3:0] rtp,
      input logic [3:0] wr);
    logic [6:0] readLimit;
    readLimit = 7'(half) + 7'(rtp) - 7'h02;
    if (isWrite) begin
      return 7'(wl) + 7'(half) + 7'h01 + 7'(wr);
    end else if (readLimit > 7'(half)) begin
      return readLimit;
    end else begin
      return 7'(half);
    end
  endfunction : autoDelay

endpackage : bank_close_pkg

// [inc/beat_group_if.sv]
`timescale 1ns/100ps
// Carries accepted write beats in and assembled prefetch groups out.
interface beat_group_if;
  logic beatValid;
  logic [31:0] beatData;
  logic [3:0] beatMask;
  logic groupValid;
  logic [127:0] groupData;
  logic [15:0] groupByteEn;
  modport feeder (output beatValid, beatData, beatMask,
                  input groupValid, groupData, groupByteEn);
  modport gatherer (input beatValid, beatData, beatMask,
                    output groupValid, groupData, groupByteEn);
endinterface : beat_group_if

// [rtl/write_group_gather.sv]
`timescale 1ns/100ps
module write_group_gather (
  input wire logic core_clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  beat_group_if.gatherer beats // Beat input and group output.
);

  logic [1:0] beatCount;
  logic [95:0] heldData;
  logic [11:0] heldMask;

  // Collects beats and releases a group once four are latched.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      beatCount <= 2'h0;
      heldData <= 96'h0;
      heldMask <= 12'h000;
      beats.groupValid <= 1'b0;
      beats.groupData <= 128'h0;
      beats.groupByteEn <= 16'h0000;
    end else begin
      beats.groupValid <= 1'b0;
      if (beats.beatValid) begin
        beatCount <= beatCount + 2'h1;
        heldData <= {beats.beatData, heldData[95:32]};
        heldMask <= {beats.beatMask, heldMask[11:4]};
        if (beatCount == 2'(bank_close_pkg::GROUP_BEATS - 1)) begin
          beats.groupValid <= 1'b1;
          beats.groupData <= {beats.beatData, heldData};
          beats.groupByteEn <= ~{beats.beatMask, heldMask};
        end
      end
    end
  end

endmodule : write_group_gather

// [rtl/dram_bank_close.sv]
`timescale 1ns/100ps
module dram_bank_close (
  input wire logic core_clk, // System clock, 100 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic cmdClk, // Command clock from the controller.
  input wire logic cmdSelN, // Chip select, active low.
  input wire logic [9:0] cmdAddr, // Command and address bus.
  input wire logic dataStrobe, // Write data strobe.
  input wire logic [31:0] writeData, // Write data bits.
  input wire logic [3:0] writeByteMask, // Per lane write mask.
  output logic closeStart, // Pulse when banks begin closing.
  output logic [7:0] closeBanks, // Banks closing with that pulse.
  output logic closeAllBank, // Closing came from an all-bank command.
  output logic arrayWrite, // Pulse committing one prefetch group.
  output logic [127:0] arrayData, // Four beats, first beat lowest.
  output logic [15:0] arrayByteEn // Byte enables of the group.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [48:0] syncA;
  logic [48:0] syncB;
  logic clkPrev;
  logic strobePrev;
  logic linkRise;
  logic linkFall;
  logic strobeEdge;
  logic riseValid;
  logic [9:0] riseCa;
  bank_close_pkg::cmd_t cmd;
  logic cmdEvent;
  logic [31:0] ctrl;
  logic [4:0] burstLen;
  logic [3:0] writeLat;
  logic [3:0] rtpCycles;
  logic [3:0] wrCycles;
  logic [7:0] armed;
  logic [6:0] remain [8];
  logic [7:0] fireMask;
  logic [2:0] lastBank;
  logic lastWrite;
  logic lastLive;
  logic [6:0] lastAge;
  logic [6:0] truncDelay;
  logic [5:0] beatsDone;
  logic [5:0] beatsTotal;
  logic [7:0] lastCloseMask;
  logic lastAllBank;
  beat_group_if beats ();

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************

  // Every link pin passes two flops before use.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncA <= 49'h0;
      syncB <= 49'h0;
      clkPrev <= 1'b0;
      strobePrev <= 1'b0;
    end else begin
      syncA <= {cmdClk, dataStrobe, cmdSelN, cmdAddr, writeByteMask,
                writeData};
      syncB <= syncA;
      clkPrev <= syncB[48];
      strobePrev <= syncB[47];
    end
  end

  // Edges of the command clock and of the data strobe.
  assign linkRise = syncB[48] & ~clkPrev;
  assign linkFall = ~syncB[48] & clkPrev;
  assign strobeEdge = syncB[47] ^ strobePrev;

  // ****************************************************************
  // Command capture
  // ****************************************************************

  // Holds rising-edge bits until the falling half of the command arrives.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      riseValid <= 1'b0;
      riseCa <= 10'h000;
    end else if (linkRise) begin
      riseValid <= ~syncB[46];
      riseCa <= syncB[45:36];
    end else if (linkFall) begin
      riseValid <= 1'b0;
    end
  end

  // A whole command is complete at the falling edge.
  assign cmdEvent = linkFall & riseValid;
  assign cmd = cmdEvent ? bank_close_pkg::decodeCmd(riseCa)
                        : bank_close_pkg::CMD_NONE;

  // ****************************************************************
  // Wishbone register file
  // ****************************************************************
  assign burstLen = ctrl[bank_close_pkg::BL_LSB +: 5];
  assign writeLat = ctrl[bank_close_pkg::WL_LSB +: 4];
  assign rtpCycles = ctrl[bank_close_pkg::RTP_LSB +: 4];
  assign wrCycles = ctrl[bank_close_pkg::WR_LSB +: 4];

  // Acknowledges one cycle after the request and drops ack next cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= bank_close_pkg::CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_adr_i == bank_close_pkg::CTRL_ADDR) begin
          for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
              ctrl[8*i +: 8] <= wb_dat_i[8*i +: 8];
            end
          end
        end else if (!wb_we_i) begin
          case (wb_adr_i)
            bank_close_pkg::CTRL_ADDR: wb_dat_o <= ctrl;
            bank_close_pkg::STATUS_ADDR: begin
              wb_dat_o <= {8'h00, armed, 7'h00, lastAllBank, lastCloseMask};
            end
            default: wb_dat_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Most recent read or write, for burst truncation
  // ****************************************************************

  // Counts command clock rises since the last read or write.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lastBank <= 3'h0;
      lastWrite <= 1'b0;
      lastLive <= 1'b0;
      lastAge <= 7'h00;
    end else if (cmd == bank_close_pkg::CMD_READ ||
                 cmd == bank_close_pkg::CMD_WRITE) begin
      lastBank <= riseCa[9:7];
      lastWrite <= (cmd == bank_close_pkg::CMD_WRITE);
      lastLive <= 1'b1;
      lastAge <= 7'h00;
    end else if (cmd == bank_close_pkg::CMD_TERM) begin
      lastLive <= 1'b0;
    end else if (linkRise && lastAge != 7'h7f) begin
      lastAge <= lastAge + 7'h01;
    end
  end

  // Delay to the close when the burst is cut to twice its age.
  assign truncDelay = bank_close_pkg::autoDelay(lastWrite, lastAge[4:0],
      writeLat, rtpCycles, wrCycles);

  // ****************************************************************
  // Automatic close timers, one per bank
  // ****************************************************************

  // Banks whose timer expires on this command clock rise.
  always_comb begin
    fireMask = 8'h00;
    for (int b = 0; b < 8; b++) begin
      fireMask[b] = linkRise & armed[b] & (remain[b] == 7'h01);
    end
  end

  // Arms a timer on an auto-close access, retimes it on a terminate.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      armed <= 8'h00;
      for (int b = 0; b < 8; b++) begin
        remain[b] <= 7'h00;
      end
    end else if (cmd == bank_close_pkg::CMD_READ ||
                 cmd == bank_close_pkg::CMD_WRITE) begin
      armed[riseCa[9:7]] <= syncB[36];
      remain[riseCa[9:7]] <= bank_close_pkg::autoDelay(
          cmd == bank_close_pkg::CMD_WRITE, burstLen >> 1, writeLat,
          rtpCycles, wrCycles);
    end else if (cmd == bank_close_pkg::CMD_TERM && lastLive) begin
      if (truncDelay > lastAge) begin
        remain[lastBank] <= truncDelay - lastAge;
      end else begin
        remain[lastBank] <= 7'h01;
      end
    end else if (cmd == bank_close_pkg::CMD_CLOSE) begin
      if (riseCa[4]) begin
        armed <= 8'h00;
      end else begin
        armed[riseCa[9:7]] <= 1'b0;
      end
    end else if (linkRise) begin
      armed <= armed & ~fireMask;
      for (int b = 0; b < 8; b++) begin
        if (armed[b]) begin
          remain[b] <= remain[b] - 7'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Close outputs
  // ****************************************************************

  // Reports explicit and automatic closes.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      closeStart <= 1'b0;
      closeBanks <= 8'h00;
      closeAllBank <= 1'b0;
      lastCloseMask <= 8'h00;
      lastAllBank <= 1'b0;
    end else begin
      closeStart <= 1'b0;
      if (cmd == bank_close_pkg::CMD_CLOSE) begin
        closeStart <= 1'b1;
        closeAllBank <= riseCa[4];
        closeBanks <= riseCa[4] ? 8'hff
                                : 8'h01 << riseCa[9:7];
        lastCloseMask <= riseCa[4] ? 8'hff : 8'h01 << riseCa[9:7];
        lastAllBank <= riseCa[4];
      end else if (fireMask != 8'h00) begin
        closeStart <= 1'b1;
        closeAllBank <= 1'b0;
        closeBanks <= fireMask;
        lastCloseMask <= fireMask;
        lastAllBank <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Write beat intake
  // ****************************************************************

  // Accepts one beat per strobe edge until the burst is complete.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      beatsDone <= 6'h00;
      beatsTotal <= 6'h00;
    end else if (cmd == bank_close_pkg::CMD_WRITE) begin
      beatsDone <= 6'h00;
      beatsTotal <= 6'(burstLen);
    end else if (cmd == bank_close_pkg::CMD_TERM && lastLive && lastWrite) begin
      beatsTotal <= 6'({lastAge[4:0], 1'b0});
    end else if (strobeEdge && beatsDone < beatsTotal) begin
      beatsDone <= beatsDone + 6'h01;
    end
  end

  assign beats.beatValid = strobeEdge & (beatsDone < beatsTotal) &
                           (cmd == bank_close_pkg::CMD_NONE);
  assign beats.beatData = syncB[31:0];
  assign beats.beatMask = syncB[35:32];
  assign arrayWrite = beats.groupValid;
  assign arrayData = beats.groupData;
  assign arrayByteEn = beats.groupByteEn;

  // Assembles beats into prefetch groups.
  write_group_gather gather (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .beats(beats.gatherer)
  );

endmodule : dram_bank_close

// [verification/dram_bank_close_checker.sv]
`timescale 1ns/100ps
// ****************************************************************
// Port checks of the bank close block.
// ****************************************************************
module dram_bank_close_checker (
  input wire logic core_clk, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic closeStart, // Close pulse.
  input wire logic [7:0] closeBanks, // Closing banks.
  input wire logic closeAllBank, // All-bank close.
  input wire logic arrayWrite // Group commit pulse.
);
  // All checks share the core clock and its reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_needs_req: assert property
    (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_read_data_idle: assert property
    (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_close_one_cycle: assert property (closeStart |=> !closeStart)
    else $error("close pulse too long");
  a_single_bank_onehot: assert property (
    closeStart && !closeAllBank |-> $onehot(closeBanks))
    else $error("single close not one bank");
  a_all_bank_mask: assert property (
    closeStart && closeAllBank |-> closeBanks == 8'hff)
    else $error("all-bank close not all banks");
  a_close_mask_holds: assert property (
    !closeStart |-> $stable(closeBanks) && $stable(closeAllBank))
    else $error("close mask changed without pulse");
  a_group_spacing: assert property (
    arrayWrite |=> !arrayWrite [*3])
    else $error("groups closer than four beats");

  // Main scenarios.
  cover property (closeStart && closeAllBank);
  cover property (closeStart && !closeAllBank);
  cover property (arrayWrite);
endmodule : dram_bank_close_checker

bind dram_bank_close dram_bank_close_checker i_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .closeStart(closeStart), .closeBanks(closeBanks),
  .closeAllBank(closeAllBank), .arrayWrite(arrayWrite));

// [verification/mem_ctrl_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// Memory controller model driving the command link and write data.
// ****************************************************************
module mem_ctrl_model (
  input wire logic core_clk, // Bench clock that paces the link.
  output logic cmdClk, // Command clock, still between frames.
  output logic cmdSelN, // Chip select, active low.
  output logic [9:0] cmdAddr, // Command and address bits.
  output logic dataStrobe, // Write strobe, idle low.
  output logic [31:0] writeData, // Write data beats.
  output logic [3:0] writeByteMask // Masks, high skips a byte.
);
  int riseCount = 0;

  // Idle levels before the first frame.
  initial begin
    cmdClk = 1'b0;
    cmdSelN = 1'b1;
    cmdAddr = 10'h000;
    dataStrobe = 1'b0;
    writeData = 32'h0000_0000;
    writeByteMask = 4'h0;
  end

  // One 80 ns link cycle; rise bits then fall bits, then inverted lines.
  task automatic cmd(input logic [9:0] r, input logic [9:0] f,
      input logic sel);
    cmdSelN <= !sel;
    cmdAddr <= r;
    repeat (2) @(posedge core_clk);
    cmdClk <= 1'b1;
    riseCount <= riseCount + 1;
    repeat (2) @(posedge core_clk);
    cmdAddr <= f;
    repeat (2) @(posedge core_clk);
    cmdClk <= 1'b0;
    @(posedge core_clk);
    cmdSelN <= 1'b1;
    cmdAddr <= ~f;
    @(posedge core_clk);
  endtask : cmd

  // Deselected cycles that keep the link clock running.
  task automatic nop(input int n);
    repeat (n) cmd(~cmdAddr, cmdAddr, 1'b0);
  endtask : nop

  // One beat; the mask moves with the data around the strobe edge.
  task automatic beat(input logic [31:0] d, input logic [3:0] m);
    writeData <= d;
    writeByteMask <= m;
    repeat (3) @(posedge core_clk);
    dataStrobe <= !dataStrobe;
    repeat (2) @(posedge core_clk);
    writeData <= ~d;
    writeByteMask <= ~m;
    @(posedge core_clk);
  endtask : beat
endmodule : mem_ctrl_model

// [verification/tb_dram_bank_close_and_write_mask.sv]
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench of the bank close block.
// ****************************************************************
module tb_dram_bank_close_and_write_mask;
  logic core_clk = 1'b0;
  logic sys_rst, wbCyc, wbStb, wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW;
  logic [31:0] rdData;
  logic ack, closeStart, closeAllBank, arrayWrite;
  logic [7:0] closeBanks;
  logic [127:0] arrayData;
  logic [15:0] arrayByteEn;
  logic cmdClk, cmdSelN, dataStrobe;
  logic [9:0] cmdAddr;
  logic [31:0] writeData;
  logic [3:0] writeByteMask;
  logic [31:0] regQ[$];
  logic [8:0] closeQ[$];
  int riseQ[$];
  logic [143:0] groupQ[$];
  int miscompares = 0, compares = 0, seed = 32'h3741_33ed, monR;

  always #5 core_clk = ~core_clk;

  dram_bank_close i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(rdData),
    .wb_ack_o(ack), .cmdClk(cmdClk), .cmdSelN(cmdSelN),
    .cmdAddr(cmdAddr), .dataStrobe(dataStrobe), .writeData(writeData),
    .writeByteMask(writeByteMask), .closeStart(closeStart),
    .closeBanks(closeBanks), .closeAllBank(closeAllBank),
    .arrayWrite(arrayWrite), .arrayData(arrayData),
    .arrayByteEn(arrayByteEn));
  mem_ctrl_model i_ctrl (.core_clk(core_clk), .cmdClk(cmdClk),
    .cmdSelN(cmdSelN), .cmdAddr(cmdAddr), .dataStrobe(dataStrobe),
    .writeData(writeData), .writeByteMask(writeByteMask));

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic bus cycle, held until ack is sampled high.
  task automatic wbXfer(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    wbSel <= sel;
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) begin
      miscompares++;
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask : wbXfer

  // Reads a register and notes the value it must return.
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    regQ.push_back(exp);
    wbXfer(1'b0, adr, 32'($random(seed)), 4'hf);
  endtask : rd

  // Sends a close command and notes the banks it must close.
  task automatic closeCmd(input logic all, input logic [2:0] bank);
    closeQ.push_back({all, all ? 8'hff : 8'h01 << bank});
    riseQ.push_back(-1);
    i_ctrl.cmd({bank, 2'($random(seed)), all, 4'hb}, 10'($random(seed)),
      1'b1);
  endtask : closeCmd

  // Sends a read or write and notes any automatic close with its rise.
  task automatic access(input logic wr, input logic [2:0] bank,
      input logic auto, input int delay);
    if (auto) begin
      closeQ.push_back({1'b0, 8'h01 << bank});
      riseQ.push_back(i_ctrl.riseCount + 1 + delay);
    end
    i_ctrl.cmd({bank, 4'($random(seed)), wr ? 3'b001 : 3'b101},
      {9'($random(seed)), auto}, 1'b1);
  endtask : access

  // Sends random beats and notes each group of four.
  task automatic sendBeats(input int n);
    logic [127:0] d;
    logic [15:0] e;
    logic [31:0] w;
    logic [3:0] m;
    for (int i = 0; i < n; i++) begin
      w = $random(seed);
      m = 4'($random(seed));
      d[32*(i%4) +: 32] = w;
      e[4*(i%4) +: 4] = ~m;
      if (i % 4 == 3) begin
        groupQ.push_back({e, d});
      end
      i_ctrl.beat(w, m);
    end
  endtask : sendBeats

  // Takes the oldest note whenever the design shows a result.
  always @(posedge core_clk) begin
    if (ack === 1'b1 && wbWe === 1'b0) begin
      check(144'(regQ.size() > 0), 144'h1);
      if (regQ.size() > 0) check(144'(rdData), 144'(regQ.pop_front()));
    end
    if (closeStart === 1'b1) begin
      check(144'(closeQ.size() > 0), 144'h1);
      if (closeQ.size() > 0) begin
        monR = riseQ.pop_front();
        check(144'({closeAllBank, closeBanks}), 144'(closeQ.pop_front()));
        if (monR >= 0) check(144'(i_ctrl.riseCount), 144'(monR));
      end
    end
    if (arrayWrite === 1'b1) begin
      check(144'(groupQ.size() > 0), 144'h1);
      if (groupQ.size() > 0) check({arrayByteEn, arrayData},
        groupQ.pop_front());
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    check(144'(regQ.size() + closeQ.size() + groupQ.size()), 144'h0);
    $display("Compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  // Main sequence.
  initial begin
    sys_rst <= 1'b1;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbAdr <= 8'h00;
    wbSel <= 4'h0;
    wbDatW <= 32'h0000_0000;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(bank_close_pkg::CTRL_ADDR, bank_close_pkg::CTRL_RESET);
    wbXfer(1'b1, bank_close_pkg::STATUS_ADDR, 32'hffff_ffff, 4'hf);
    wbXfer(1'b1, 8'h08, 32'h1234_5678, 4'hf);
    rd(8'h08, 32'h0000_0000);
    rd(bank_close_pkg::STATUS_ADDR, 32'h0000_0000);
    $display("Test registers finished");
    for (int b = 0; b < 8; b++) closeCmd(1'b0, 3'(b));
    closeCmd(1'b1, 3'($random(seed)));
    i_ctrl.cmd(10'h00b, 10'h000, 1'b0);
    rd(bank_close_pkg::STATUS_ADDR, 32'h0000_01ff);
    $display("Test closes finished");
    access(1'b1, 3'h3, 1'b1, 8);
    sendBeats(8);
    i_ctrl.nop(10);
    $display("Test masked write finished");
    access(1'b0, 3'h5, 1'b0, 0);
    i_ctrl.nop(6);
    access(1'b0, 3'h5, 1'b1, 4);
    i_ctrl.nop(6);
    wbXfer(1'b1, bank_close_pkg::CTRL_ADDR, 32'h0f0f_0f04, 4'h1);
    rd(bank_close_pkg::CTRL_ADDR, {bank_close_pkg::CTRL_RESET[31:8], 8'h04});
    access(1'b0, 3'h4, 1'b1, 2);
    i_ctrl.nop(4);
    wbXfer(1'b1, bank_close_pkg::CTRL_ADDR, 32'h0105_0208, 4'hf);
    rd(bank_close_pkg::CTRL_ADDR, 32'h0105_0208);
    access(1'b0, 3'h6, 1'b1, 7);
    i_ctrl.nop(9);
    $display("Test read close finished");
    access(1'b1, 3'h1, 1'b1, 6);
    i_ctrl.nop(1);
    i_ctrl.cmd({6'($random(seed)), 4'h3}, 10'($random(seed)), 1'b1);
    sendBeats(4);
    i_ctrl.nop(8);
    $display("Test truncated write finished");
    access(1'b0, 3'h0, 1'b1, 5);
    i_ctrl.nop(1);
    i_ctrl.cmd({6'($random(seed)), 4'h3}, 10'($random(seed)), 1'b1);
    i_ctrl.nop(6);
    $display("Test truncated read finished");
    i_ctrl.cmd({3'h2, 4'h0, 3'b101}, 10'h001, 1'b1);
    i_ctrl.nop(3);
    closeCmd(1'b0, 3'h2);
    i_ctrl.nop(10);
    $display("Test disarm finished");
    finish_test();
  end
endmodule : tb_dram_bank_close_and_write_mask
